// ---- dv/obcdc_host_model.sv ----
/* host side of the bank c slice: byte writes, reads, init toggles.
   assumes it shares i_mclk with the slice and is called by the bench. */
`timescale 1ns/1ps
module obcdc_host_model
  import obcdc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output obcdc_req_s      o_req,
  output logic            o_div_init
);
  initial begin
    o_req      = '0;
    o_div_init = 1'b0;
  end
  // bits that may carry a one
  function automatic logic [7:0] live(input logic [7:0] a);
    case (a)
      8'h20:        return 8'h3f;
      8'h22:        return 8'h81;
      8'h24, 8'h25: return 8'h87;
      default:      return 8'h00;
    endcase
  endfunction : live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_req <= '{1'b1, 1'b0, a, d & live(a)};
    @(posedge i_mclk);
    o_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge i_mclk);
    o_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_mclk);
    o_req.rd <= 1'b0;
    #1;
    v = i_rvalid;
    d = i_rdata & live(a);
  endtask : rd
  task automatic tog();
    @(posedge i_mclk);
    o_div_init <= ~o_div_init;
  endtask : tog
endmodule : obcdc_host_model

// ---- dv/tb_top.sv ----
/* self-checking bench for the bank c slice with a host model.
   assumes the package constants and one 125 mhz clock. */
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %0t got %h exp %h", $time, a, e); end end
module tb_top;
  import obcdc_pkg::*;
  logic       i_mclk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic [1:0] pins = 2'h0;
  obcdc_req_s req;
  logic       init;
  logic [7:0] rdata;
  logic       rvalid;
  obcdc_cfg_s cfg;
  logic [7:0] ratio;
  logic       rok;
  logic [9:0] mv0;
  logic [9:0] mv1;
  int         err_count = 0;
  int         n_tests = 0;

  obcdc_host_model host (.i_mclk(i_mclk), .i_rdata(rdata),
    .i_rvalid(rvalid), .o_req(req), .o_div_init(init));
  obcdc_bank_cfg dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_req(req),
    .i_div_init(init), .i_bank_sel_pins(pins), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_cfg(cfg), .o_divide_ratio(ratio),
    .o_ratio_valid(rok), .o_swing_mv0(mv0), .o_swing_mv1(mv1));

  initial forever #4 i_mclk = ~i_mclk;

  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : settle
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask : rdchk
  task automatic t_reset();
    `CHK(cfg.ratio_code, 6'h0d)
    `CHK(ratio, 8'd16)
    `CHK(rok, 1'b1)
    `CHK(cfg.bank_power_off, 1'b0)
    `CHK(cfg.out_power_off, 2'b00)
    `CHK(cfg.out_driver_kind, 2'b00)
    `CHK(mv0, 10'd350)
    rdchk(8'h20, 8'h0d);
    rdchk(8'h22, 8'h00);
    rdchk(8'h24, 8'h00);
    rdchk(8'h21, 8'h00);
  endtask : t_reset
  task automatic t_ratio();
    logic [5:0] code [4] = '{6'h3b, 6'h3c, 6'h00, 6'h01};
    logic [7:0] exp  [4] = '{8'd220, 8'd0, 8'd0, 8'd1};
    host.wr(8'h22, 8'h01);
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h20, {2'b11, code[i]});
      rdchk(8'h20, {2'b00, code[i]});
      settle(2);
      `CHK(cfg.ratio_code, i == 0 ? 6'h0d : code[i-1])
      host.tog();
      settle(3);
      `CHK(cfg.ratio_code, code[i])
      `CHK(rok, exp[i] != 8'd0)
      if (exp[i] != 8'd0) `CHK(ratio, exp[i])
    end
  endtask : t_ratio
  task automatic t_drive();
    logic [9:0] mv [3] = '{10'd350, 10'd500, 10'd750};
    for (int s = 0; s < 3; s++) begin
      host.wr(8'h24, 8'h84 | 8'(s));
      host.wr(8'h25, 8'(2 - s));
      settle(3);
      `CHK(cfg.out_power_off, 2'b01)
      `CHK(cfg.out_driver_kind, 2'b01)
      `CHK(cfg.out_swing_level[0], 2'(s))
      `CHK(mv0, mv[s])
      `CHK(mv1, mv[2-s])
    end
    host.wr(8'h25, 8'h03);
    settle(3);
    `CHK(mv1, MV_NONE)
    host.wr(8'h22, 8'h81);
    settle(3);
    `CHK(cfg.bank_power_off, 1'b1)
    rdchk(8'h22, 8'h81);
  endtask : t_drive
  task automatic t_pins();
    host.wr(8'h22, 8'h80);
    @(posedge i_mclk);
    pins <= 2'h2;
    settle(5);
    `CHK(cfg.bank_power_off, 1'b0)
    `CHK(mv0, 10'd350)
    host.tog();
    settle(3);
    `CHK(ratio, 8'd32)
    @(posedge i_mclk);
    pins <= 2'h3;
    settle(6);
    `CHK(ratio, 8'd32)
    host.tog();
    settle(3);
    `CHK(ratio, 8'd48)
  endtask : t_pins

  task automatic tally_and_finish();
    $display("errors %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    settle(1);
    t_reset();
    t_ratio();
    t_drive();
    t_pins();
    tally_and_finish();
  end
  // about 110 cycles are expected
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
endmodule : tb_top

// ---- logic/obcdc_bank_cfg.sv ----
/*
 * bank c configuration slice: byte registers 20h..25h, pin or register
 * source select, divider held until the init toggle, per-output drive.
 * assumes the byte request port is driven by the serial slave engine on
 * i_mclk and the divider-init bit is a level from a register on i_mclk.
 */
// How it works
// - divide code maps by fixed table to 1..220; zero and top four reserved
// - new divide ratio waits until the divider-init bit toggles
// - divide code in bits 5:0 of byte 20h; 21h all reserved
// - 22h bank off bit 7, source bit 0; 24h/25h off, style, swing
// - bank power-off resets to zero, one powers the bank down
// - source zero takes settings from pins, one from registers
// - each output power-off bit resets zero, one powers output down
// - style bit zero selects lvds, one selects lvpecl
// - swing 00=350, 01=500, 10=750 mv, 11 reserved
`timescale 1ns/1ps
module obcdc_bank_cfg
  import obcdc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  obcdc_req_s      i_req,
  input  wire logic       i_div_init,
  input  wire logic [1:0] i_bank_sel_pins,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  output obcdc_cfg_s      o_cfg,
  output logic      [7:0] o_divide_ratio,
  output logic            o_ratio_valid,
  output logic      [9:0] o_swing_mv0,
  output logic      [9:0] o_swing_mv1
);

  function automatic logic [9:0] swing_mv(input logic [1:0] code);
    unique case (code)
      SWING_350: swing_mv = MV_350;
      SWING_500: swing_mv = MV_500;
      SWING_750: swing_mv = MV_750;
      default:   swing_mv = MV_NONE;
    endcase
  endfunction : swing_mv

  logic [5:0]      div_code_reg;
  logic            bank_off_reg;
  logic            src_sel_reg;
  logic [1:0]      out_off_reg;
  logic [1:0]      kind_reg;
  logic [1:0][1:0] swing_reg;
  logic [5:0]      act_code;
  logic            init_prev;
  logic [1:0]      pin_meta;
  logic [1:0]      pin_sync;

  // register decode
  wire logic wr_div  = i_req.wr && (i_req.addr == ADDR_DIV);
  wire logic wr_pwr  = i_req.wr && (i_req.addr == ADDR_PWR_SRC);
  wire logic wr_out0 = i_req.wr && (i_req.addr == ADDR_OUT0);
  wire logic wr_out1 = i_req.wr && (i_req.addr == ADDR_OUT1);

  wire logic [7:0] rd_div  = {2'b00, div_code_reg};
  wire logic [7:0] rd_pwr  = {bank_off_reg, 6'h00, src_sel_reg};
  wire logic [7:0] rd_out0 = {out_off_reg[0], 4'h0, kind_reg[0],
                              swing_reg[0]};
  wire logic [7:0] rd_out1 = {out_off_reg[1], 4'h0, kind_reg[1],
                              swing_reg[1]};
  // reserved bytes and bits read as zero
  wire logic [7:0] next_rdata =
    (i_req.addr == ADDR_DIV)     ? rd_div  :
    (i_req.addr == ADDR_PWR_SRC) ? rd_pwr  :
    (i_req.addr == ADDR_OUT0)    ? rd_out0 :
    (i_req.addr == ADDR_OUT1)    ? rd_out1 : 8'h00;

  // source selection
  wire logic [5:0] pin_code = PIN_CODE[pin_sync];
  wire logic [5:0] sel_code = src_sel_reg ? div_code_reg : pin_code;
  wire logic       init_evt = i_div_init ^ init_prev;

  obcdc_cfg_s next_cfg;
  always_comb begin
    next_cfg                 = '0; // pin mode: powered, lvds, 350 mv
    next_cfg.ratio_code      = act_code;
    if (src_sel_reg) begin
      next_cfg.bank_power_off  = bank_off_reg;
      next_cfg.out_power_off   = out_off_reg;
      next_cfg.out_driver_kind = kind_reg;
      next_cfg.out_swing_level = swing_reg;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      div_code_reg <= DIV_RESET;
      bank_off_reg <= OFF_RESET;
      src_sel_reg  <= SRC_RESET;
      out_off_reg  <= {2{OFF_RESET}};
      kind_reg     <= {2{KIND_RESET}};
      swing_reg    <= {2{SWING_RESET}};
    end else begin
      if (wr_div)
        div_code_reg <= i_req.wdata[5:0];
      if (wr_pwr) begin
        bank_off_reg <= i_req.wdata[BIT_BANK_OFF];
        src_sel_reg  <= i_req.wdata[BIT_SRC_SEL];
      end
      if (wr_out0) begin
        out_off_reg[0] <= i_req.wdata[BIT_OUT_OFF];
        kind_reg[0]    <= i_req.wdata[BIT_KIND];
        swing_reg[0]   <= i_req.wdata[BIT_SWING_HI:BIT_SWING_LO];
      end
      if (wr_out1) begin
        out_off_reg[1] <= i_req.wdata[BIT_OUT_OFF];
        kind_reg[1]    <= i_req.wdata[BIT_KIND];
        swing_reg[1]   <= i_req.wdata[BIT_SWING_HI:BIT_SWING_LO];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      act_code  <= DIV_RESET;
      init_prev <= 1'b0;
    end else begin
      init_prev <= i_div_init;
      if (init_evt)
        act_code <= sel_code;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      pin_meta <= i_bank_sel_pins;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
      o_cfg        <= '{ratio_code: DIV_RESET, default: '0};
      o_swing_mv0  <= MV_350;
      o_swing_mv1  <= MV_350;
    end else begin
      o_reg_rvalid <= i_req.rd;
      if (i_req.rd)
        o_reg_rdata <= next_rdata;
      o_cfg       <= next_cfg;
      o_swing_mv0 <= swing_mv(next_cfg.out_swing_level[0]);
      o_swing_mv1 <= swing_mv(next_cfg.out_swing_level[1]);
    end
  end

  obcdc_ratio_rom u_ratio_rom (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_code    (act_code),
    .o_ratio   (o_divide_ratio),
    .o_valid   (o_ratio_valid)
  );

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  chk_reset_values: assert property (
    $fell(i_sys_rst) |-> div_code_reg == DIV_RESET && !src_sel_reg
      && !bank_off_reg && out_off_reg == 2'h0)
    else $error("reset values wrong");
  chk_ratio_hold: assert property (
    !init_evt |=> $stable(act_code))
    else $error("divide code moved without init toggle");
  chk_ratio_apply: assert property (
    init_evt |=> act_code == $past(sel_code) ##1
      o_divide_ratio == RATIO_TAB[$past(sel_code, 2)])
    else $error("divide ratio not applied on toggle");
  chk_reserved_code: assert property (
    (act_code == 6'h00 || act_code > 6'h3b) |=> !o_ratio_valid)
    else $error("reserved code flagged valid");
  chk_div_layout: assert property (
    i_req.rd && i_req.addr == ADDR_DIV |=>
      o_reg_rvalid && o_reg_rdata == {2'b00, $past(div_code_reg)})
    else $error("divide byte read wrong");
  chk_rsvd_byte: assert property (
    i_req.rd && i_req.addr == ADDR_RSVD_A |=> o_reg_rdata == 8'h00)
    else $error("reserved byte not zero");
  chk_pwr_layout: assert property (
    i_req.wr && i_req.addr == ADDR_PWR_SRC |=>
      bank_off_reg == $past(i_req.wdata[7])
      && src_sel_reg == $past(i_req.wdata[0]))
    else $error("power byte write wrong");
  chk_bank_off: assert property (
    src_sel_reg && bank_off_reg |=> o_cfg.bank_power_off)
    else $error("bank not powered down");
  chk_pin_source: assert property (
    !src_sel_reg |=> o_cfg.bank_power_off == 1'b0
      && o_cfg.out_driver_kind == 2'h0)
    else $error("pin mode took register values");
  chk_out_off: assert property (
    src_sel_reg |=> o_cfg.out_power_off == $past(out_off_reg))
    else $error("output power-off not passed");
  chk_kind_map: assert property (
    src_sel_reg |=> o_cfg.out_driver_kind == $past(kind_reg))
    else $error("driver kind not passed");
  chk_swing_mv: assert property (
    src_sel_reg && swing_reg[0] == SWING_500 |=> o_swing_mv0 == MV_500)
    else $error("swing level wrong");
  chk_swing_rsvd: assert property (
    src_sel_reg && swing_reg[1] == 2'h3 |=> o_swing_mv1 == MV_NONE)
    else $error("reserved swing code decoded as a level");
  chk_pin_ratio: assert property (
    init_evt && !src_sel_reg |=> act_code == PIN_CODE[$past(pin_sync)])
    else $error("pin mode divide code not taken from pins");

  cov_init_toggle: cover property (init_evt && src_sel_reg);
  cov_swing_rsvd:  cover property (src_sel_reg && swing_reg[1] == 2'h3);
  cov_pin_mode:    cover property (init_evt && !src_sel_reg);
  cov_reserved:    cover property (init_evt && sel_code == 6'h00);
  cov_write_div:   cover property (wr_div ##[1:20] init_evt);

endmodule : obcdc_bank_cfg

// ---- logic/obcdc_pkg.sv ----
/*
 * constants, table and carrier types for the bank c divider and driver
 * configuration slice. assumes one 125 mhz clock and a byte-wide register
 * port fed by the serial slave engine in the same clock domain.
 */
package obcdc_pkg;

  // byte addresses on the register port
  localparam logic [7:0] ADDR_DIV      = 8'h20;
  localparam logic [7:0] ADDR_RSVD_A   = 8'h21;
  localparam logic [7:0] ADDR_PWR_SRC  = 8'h22;
  localparam logic [7:0] ADDR_RSVD_B   = 8'h23;
  localparam logic [7:0] ADDR_OUT0     = 8'h24;
  localparam logic [7:0] ADDR_OUT1     = 8'h25;

  // field positions
  localparam int BIT_BANK_OFF  = 7;
  localparam int BIT_SRC_SEL   = 0;
  localparam int BIT_OUT_OFF   = 7;
  localparam int BIT_KIND      = 2;
  localparam int BIT_SWING_HI  = 1;
  localparam int BIT_SWING_LO  = 0;

  // reset values
  localparam logic [5:0] DIV_RESET   = 6'h0d;
  localparam logic       OFF_RESET   = 1'b0;
  localparam logic       SRC_RESET   = 1'b0;
  localparam logic       KIND_RESET  = 1'b0;
  localparam logic [1:0] SWING_RESET = 2'h0;

  // swing codes and levels in millivolts
  localparam logic [1:0] SWING_350 = 2'h0;
  localparam logic [1:0] SWING_500 = 2'h1;
  localparam logic [1:0] SWING_750 = 2'h2;
  localparam logic [9:0] MV_350    = 10'd350;
  localparam logic [9:0] MV_500    = 10'd500;
  localparam logic [9:0] MV_750    = 10'd750;
  localparam logic [9:0] MV_NONE   = 10'h000;

  // divide ratio per code; zero marks a reserved code
  localparam logic [7:0] RATIO_TAB [64] = '{
    8'd0,   8'd1,   8'd2,   8'd3,   8'd4,   8'd5,   8'd6,   8'd8,
    8'd9,   8'd10,  8'd12,  8'd14,  8'd15,  8'd16,  8'd18,  8'd20,
    8'd21,  8'd22,  8'd24,  8'd25,  8'd27,  8'd28,  8'd30,  8'd32,
    8'd33,  8'd35,  8'd36,  8'd40,  8'd42,  8'd44,  8'd45,  8'd48,
    8'd50,  8'd54,  8'd55,  8'd56,  8'd60,  8'd64,  8'd66,  8'd70,
    8'd72,  8'd80,  8'd84,  8'd88,  8'd90,  8'd96,  8'd100, 8'd108,
    8'd110, 8'd112, 8'd120, 8'd128, 8'd132, 8'd140, 8'd144, 8'd160,
    8'd176, 8'd180, 8'd200, 8'd220, 8'd0,   8'd0,   8'd0,   8'd0
  };
  localparam logic [7:0] RATIO_RESET = 8'd16;

  // divide code chosen by each state of the two bank select pins
  localparam logic [5:0] PIN_CODE [4] = '{6'h0d, 6'h0f, 6'h17, 6'h1f};

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } obcdc_req_s;

  typedef struct packed {
    logic [5:0]      ratio_code;
    logic            bank_power_off;
    logic [1:0]      out_power_off;
    logic [1:0]      out_driver_kind;
    logic [1:0][1:0] out_swing_level;
  } obcdc_cfg_s;

endpackage : obcdc_pkg

// ---- logic/obcdc_ratio_rom.sv ----
/*
 * divide ratio lookup with registered output.
 * assumes the code input comes from logic on the same clock.
 */
`timescale 1ns/1ps
module obcdc_ratio_rom
  import obcdc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic [5:0] i_code,
  output logic      [7:0] o_ratio,
  output logic            o_valid
);

  wire logic [7:0] next_ratio = RATIO_TAB[i_code];

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_ratio <= RATIO_RESET;
      o_valid <= 1'b1;
    end else begin
      o_ratio <= next_ratio;
      o_valid <= (next_ratio != 8'h00);
    end
  end

endmodule : obcdc_ratio_rom
